// ---- rtl/sadr_pkg.sv ----
package sadr_pkg;
    localparam int ADDR_W = 32;
    localparam int NMST = 2;
    localparam int MST_CORE = 0;
    localparam int MST_DMA = 1;
    localparam int NAREA_INT = 4;
    localparam int NAREA_EXT = 8;
    localparam int AREA_MSB = 31;
    localparam int AREA_LSB = 28;
    localparam int SUB_MSB = 27;
    localparam int SUB_LSB = 20;
    localparam logic [3:0] AREA_INT = 4'h0;
    localparam logic [3:0] AREA_EXT_LO = 4'h1;
    localparam logic [3:0] AREA_EXT_HI = 4'h8;
    localparam logic [3:0] AREA_PERIPH = 4'hF;
    localparam logic [7:0] SUB_BOOT = 8'h00;
    localparam logic [7:0] SUB_FLASH = 8'h01;
    localparam logic [7:0] SUB_SRAM = 8'h02;
    localparam logic [7:0] SUB_ROM = 8'h03;
    localparam logic BOOT_RST = 1'b0;
    localparam logic REMAP_RST = 1'b0;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam int WS_W = 2;
    localparam int NREG = 16;
    localparam int PBASE_W = 22;
    localparam int PLOG_W = 5;
    localparam logic [4:0] PLOG_MIN = 5'h0A;
    localparam logic [4:0] PLOG_MAX = 5'h14;
    localparam int PF_DEPTH = 2;

    typedef enum logic [2:0] {
        MEM_NONE = 3'h0, MEM_FLASH = 3'h1, MEM_SRAM = 3'h2, MEM_ROM = 3'h4
    } sadr_mem_t;
    typedef enum logic [1:0] {
        CAUSE_UNDEF = 2'h0, CAUSE_ALIGN = 2'h1, CAUSE_WRITE = 2'h2, CAUSE_USER = 2'h3
    } sadr_cause_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_WAIT = 3'h2, ST_RESP = 3'h4
    } sadr_state_t;
    typedef struct packed {
        logic [NAREA_INT-1:0] int_sel;
        sadr_mem_t mem;
        logic periph;
        logic [NAREA_EXT-1:0] ext;
        logic undef;
    } sadr_dec_t;
endpackage : sadr_pkg

// ---- rtl/sadr_prot_if.sv ----
`timescale 1ns/100ps
interface sadr_prot_if;
    import sadr_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic write;
    logic user;
    logic [NREG-1:0] en;
    logic [PBASE_W-1:0] base [NREG];
    logic [PLOG_W-1:0] lg [NREG];
    logic [NREG-1:0] no_wr;
    logic [NREG-1:0] no_user;
    logic deny_wr;
    logic deny_user;
    modport ctl (output addr, write, user, en, base, lg, no_wr, no_user,
                 input deny_wr, deny_user);
    modport unit (input addr, write, user, en, base, lg, no_wr, no_user,
                  output deny_wr, deny_user);
endinterface : sadr_prot_if

// ---- rtl/sadr_prot.sv ----
`timescale 1ns/100ps
module sadr_prot (
    // region checks
    sadr_prot_if.unit p
);
    import sadr_pkg::*;

    // ----------------------------------------
    // region match
    // ----------------------------------------
    // size code clamped so a bad setting still gives 1 KB..1 MB
    function automatic logic [ADDR_W-1:0] region_mask(input logic [PLOG_W-1:0] lg);
        logic [PLOG_W-1:0] c;
        c = lg;
        if (c < PLOG_MIN) c = PLOG_MIN;
        if (c > PLOG_MAX) c = PLOG_MAX;
        region_mask = {ADDR_W{1'b1}} << c;
    endfunction : region_mask

    logic [NREG-1:0] hit;
    logic [3:0] area;
    logic guarded;
    assign area = p.addr[AREA_MSB:AREA_LSB];
    assign guarded = (area == AREA_INT) || (area == AREA_PERIPH);

    genvar k;
    generate
        for (k = 0; k < NREG; k++) begin : g_reg
            logic [ADDR_W-1:0] m;
            assign m = region_mask(p.lg[k]);
            assign hit[k] = p.en[k] && guarded &&
                ((p.addr & m) == ({p.base[k], 10'h000} & m));
        end
    endgenerate

    assign p.deny_wr = p.write && |(hit & p.no_wr);
    assign p.deny_user = p.user && |(hit & p.no_user);
endmodule : sadr_prot

// ---- rtl/sadr_top.sv ----
`timescale 1ns/100ps
// Operation
// - top four bits pick sixteen 256 MB areas
// - areas one to eight drive external selects
// - area zero splits into 1 MB regions
// - area fifteen goes to peripheral bus
// - unassigned areas abort the requesting master
// - four internal, one peripheral, eight external selects
// - before remap SRAM only at its base
// - after remap SRAM also at zero
// - ROM always at its fixed base
// - flash always at its fixed base
// - boot bit two set means flash boot
// - erase clears boot bit two
// - misaligned data accesses abort
// - abort records master, type and parameters
// - arbiter grants core or dma
// - sixteen regions over internal and peripherals
// - region size 1 KB to 1 MB
// - regions block writes, user or both
// - zero to three flash wait states
// - dual word prefetch skips sequential waits
// - forbidden flash operation raises interrupt
module sadr_top #(
    parameter int WS_MAX = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // masters, index 0 core, 1 dma
    input wire logic [sadr_pkg::NMST-1:0] m_req,
    input wire logic [sadr_pkg::ADDR_W-1:0] m_addr [sadr_pkg::NMST],
    input wire logic [sadr_pkg::NMST-1:0] m_write,
    input wire logic [1:0] m_size [sadr_pkg::NMST],
    input wire logic [sadr_pkg::NMST-1:0] m_fetch,
    input wire logic [sadr_pkg::NMST-1:0] m_user,
    output logic [sadr_pkg::NMST-1:0] m_gnt,
    // arbiter setup
    input wire logic arb_rr,
    input wire logic arb_dma_first,
    // answer
    output logic resp_valid,
    output logic resp_abort_r,
    output logic resp_master_r,
    // selects
    output logic [sadr_pkg::NAREA_INT-1:0] int_sel_r,
    output sadr_pkg::sadr_mem_t mem_sel_r,
    output logic periph_sel_r,
    output logic [sadr_pkg::NAREA_EXT-1:0] ext_sel_r,
    // abort status
    input wire logic abt_clr,
    output logic abt_valid_r,
    output logic abt_master_r,
    output sadr_pkg::sadr_cause_t abt_cause_r,
    output logic [sadr_pkg::ADDR_W-1:0] abt_addr_r,
    output logic abt_write_r,
    output logic [1:0] abt_size_r,
    output logic abt_fetch_r,
    output logic abt_user_r,
    // remap and boot select
    input wire logic remap_cmd,
    output logic remap_r,
    input wire logic gp_set,
    input wire logic gp_clr,
    input wire logic erase,
    output logic boot_flash_r,
    // flash controller
    input wire logic [sadr_pkg::WS_W-1:0] flash_ws,
    input wire logic flash_locked,
    input wire logic flash_irq_clr,
    output logic flash_irq_r,
    // protection regions
    input wire logic [sadr_pkg::NREG-1:0] prot_en,
    input wire logic [sadr_pkg::PBASE_W-1:0] prot_base [sadr_pkg::NREG],
    input wire logic [sadr_pkg::PLOG_W-1:0] prot_log [sadr_pkg::NREG],
    input wire logic [sadr_pkg::NREG-1:0] prot_no_wr,
    input wire logic [sadr_pkg::NREG-1:0] prot_no_user
);
    import sadr_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic sadr_dec_t decode(input logic [ADDR_W-1:0] a,
                                         input logic rmp, input logic bf);
        logic [3:0] area;
        logic [7:0] sub;
        decode = '0;
        area = a[AREA_MSB:AREA_LSB];
        sub = a[SUB_MSB:SUB_LSB];
        if (area == AREA_INT) begin
            unique case (sub)
                SUB_BOOT: decode.mem = rmp ? MEM_SRAM : (bf ? MEM_FLASH : MEM_ROM);
                SUB_FLASH: decode.mem = MEM_FLASH;
                SUB_SRAM: decode.mem = MEM_SRAM;
                SUB_ROM: decode.mem = MEM_ROM;
                default: decode.undef = 1'b1;
            endcase
            if (!decode.undef) decode.int_sel = 4'h1 << sub[1:0];
        end else if (area >= AREA_EXT_LO && area <= AREA_EXT_HI) begin
            decode.ext = 8'h01 << (area - AREA_EXT_LO);
        end else if (area == AREA_PERIPH) begin
            decode.periph = 1'b1;
        end else begin
            decode.undef = 1'b1;
        end
    endfunction : decode

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    sadr_state_t st_r;
    logic last_r;
    logic pick;
    logic take;
    always_comb begin
        if (m_req == 2'h3) pick = arb_rr ? ~last_r : arb_dma_first;
        else pick = m_req[MST_DMA];
    end
    assign take = ce && (st_r == ST_IDLE) && |m_req;
    assign m_gnt = take ? (2'h1 << pick) : 2'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) last_r <= 1'b0;
        else if (take) last_r <= pick;
    end

    // ----------------------------------------
    // access checks
    // ----------------------------------------
    logic [ADDR_W-1:0] a;
    logic wr, usr, ftc;
    logic [1:0] sz;
    sadr_dec_t dec;
    logic misal;
    logic abort;
    sadr_cause_t cause;
    sadr_prot_if pif ();

    assign a = m_addr[pick];
    assign wr = m_write[pick];
    assign usr = m_user[pick];
    assign ftc = m_fetch[pick];
    assign sz = m_size[pick];
    assign dec = decode(a, remap_r, boot_flash_r);
    assign misal = !ftc && (((sz == SZ_HALF) && a[0]) ||
                            ((sz == SZ_WORD) && (a[1:0] != 2'h0)));

    assign pif.addr = a;
    assign pif.write = wr;
    assign pif.user = usr;
    assign pif.en = prot_en;
    assign pif.base = prot_base;
    assign pif.lg = prot_log;
    assign pif.no_wr = prot_no_wr;
    assign pif.no_user = prot_no_user;

    sadr_prot u_prot (
        .p(pif.unit)
    );

    always_comb begin
        cause = CAUSE_UNDEF;
        if (dec.undef) cause = CAUSE_UNDEF;
        else if (misal) cause = CAUSE_ALIGN;
        else if (pif.deny_wr) cause = CAUSE_WRITE;
        else if (pif.deny_user) cause = CAUSE_USER;
    end
    assign abort = dec.undef || misal || pif.deny_wr || pif.deny_user;

    // ----------------------------------------
    // flash prefetch and wait states
    // ----------------------------------------
    logic [ADDR_W-3:0] pf_tag_r [PF_DEPTH];
    logic pf_vld_r;
    logic pf_hit;
    logic fl_acc;
    logic fl_slow;
    logic [WS_W-1:0] wcnt_r;
    assign fl_acc = take && !abort && (dec.mem == MEM_FLASH);
    // sequential 16-bit fetches land in the buffered pair of words
    assign pf_hit = pf_vld_r && ftc &&
        ((pf_tag_r[0] == a[ADDR_W-1:2]) || (pf_tag_r[1] == a[ADDR_W-1:2]));
    assign fl_slow = fl_acc && !pf_hit && (flash_ws != '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pf_vld_r <= 1'b0;
            pf_tag_r[0] <= '0;
            pf_tag_r[1] <= '0;
        end else if (fl_acc && ftc && !pf_hit) begin
            pf_vld_r <= 1'b1;
            pf_tag_r[0] <= a[ADDR_W-1:2];
            pf_tag_r[1] <= a[ADDR_W-1:2] + 30'h1;
        end
    end

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            wcnt_r <= '0;
        end else if (ce) begin
            unique case (st_r)
                ST_IDLE: if (take) begin
                    st_r <= fl_slow ? ST_WAIT : ST_RESP;
                    wcnt_r <= flash_ws;
                end
                ST_WAIT: begin
                    wcnt_r <= wcnt_r - 2'h1;
                    if (wcnt_r == 2'h1) st_r <= ST_RESP;
                end
                ST_RESP: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    assign resp_valid = (st_r == ST_RESP);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_sel_r <= '0;
            mem_sel_r <= MEM_NONE;
            periph_sel_r <= 1'b0;
            ext_sel_r <= '0;
            resp_abort_r <= 1'b0;
            resp_master_r <= 1'b0;
        end else if (ce) begin
            if (take) begin
                // an aborted access never reaches a target
                int_sel_r <= abort ? '0 : dec.int_sel;
                mem_sel_r <= abort ? MEM_NONE : dec.mem;
                periph_sel_r <= !abort && dec.periph;
                ext_sel_r <= abort ? '0 : dec.ext;
                resp_abort_r <= abort;
                resp_master_r <= pick;
            end else if (st_r == ST_RESP) begin
                int_sel_r <= '0;
                mem_sel_r <= MEM_NONE;
                periph_sel_r <= 1'b0;
                ext_sel_r <= '0;
                resp_abort_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // abort status capture
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            abt_valid_r <= 1'b0;
            abt_master_r <= 1'b0;
            abt_cause_r <= CAUSE_UNDEF;
            abt_addr_r <= '0;
            abt_write_r <= 1'b0;
            abt_size_r <= SZ_BYTE;
            abt_fetch_r <= 1'b0;
            abt_user_r <= 1'b0;
        end else if (ce) begin
            if (take && abort) begin
                abt_valid_r <= 1'b1;
                abt_master_r <= pick;
                abt_cause_r <= cause;
                abt_addr_r <= a;
                abt_write_r <= wr;
                abt_size_r <= sz;
                abt_fetch_r <= ftc;
                abt_user_r <= usr;
            end else if (abt_clr) begin
                abt_valid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // remap, boot select, flash fault
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) remap_r <= REMAP_RST;
        else if (ce && remap_cmd) remap_r <= 1'b1;
    end

    // nvm bit emulated in flops, so it restarts at its erased value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) boot_flash_r <= BOOT_RST;
        else if (ce) begin
            if (erase) boot_flash_r <= 1'b0;
            else if (gp_set) boot_flash_r <= 1'b1;
            else if (gp_clr) boot_flash_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) flash_irq_r <= 1'b0;
        else if (ce) begin
            if (fl_acc && wr && flash_locked) flash_irq_r <= 1'b1;
            else if (flash_irq_clr) flash_irq_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [3:0] t_area;
    assign t_area = a[AREA_MSB:AREA_LSB];

    sequence s_take_ok;
        take && !abort;
    endsequence
    sequence s_flash_miss;
        take && fl_slow;
    endsequence

    a_area_ext: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and (t_area == 4'h3)) |=> ext_sel_r == 8'h04 && !periph_sel_r)
        else $error("external area select wrong");
    a_area_unused: assert property (@(posedge clk) disable iff (!rst_n)
        (take && (t_area == 4'h9 || t_area == 4'hE)) |=> resp_abort_r && resp_valid)
        else $error("unused area did not abort");
    a_area_periph: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and (t_area == AREA_PERIPH)) |=> periph_sel_r && ext_sel_r == '0)
        else $error("peripheral select missing");
    a_zero_before: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and !remap_r && a[31:20] == 12'h000) |=> mem_sel_r != MEM_SRAM)
        else $error("sram seen at zero before remap");
    a_zero_after: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and remap_r && a[31:20] == 12'h000) |=> mem_sel_r == MEM_SRAM)
        else $error("sram missing at zero after remap");
    a_zero_boot: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and !remap_r && a[31:20] == 12'h000)
        |=> mem_sel_r == ($past(boot_flash_r) ? MEM_FLASH : MEM_ROM))
        else $error("boot alias wrong");
    a_rom_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and a[31:20] == 12'h003) |=> mem_sel_r == MEM_ROM && int_sel_r == 4'h8)
        else $error("rom not at fixed base");
    a_flash_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        (s_take_ok and a[31:20] == 12'h001) |=> mem_sel_r == MEM_FLASH)
        else $error("flash not at fixed base");
    a_erase_boot: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && erase) |=> !boot_flash_r)
        else $error("erase left boot bit set");
    a_misal_abort: assert property (@(posedge clk) disable iff (!rst_n)
        (take && !m_fetch[pick] && sz == SZ_WORD && a[1:0] == 2'h2)
        |=> resp_abort_r ##0 (abt_cause_r == CAUSE_ALIGN || $past(dec.undef)))
        else $error("misaligned word not aborted");
    a_abort_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (take && abort) |=> abt_valid_r && abt_addr_r == $past(a) &&
        abt_master_r == $past(pick) && abt_write_r == $past(wr))
        else $error("abort status not captured");
    a_grant_one: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot0(m_gnt) && (|m_gnt == take))
        else $error("grant not single");
    a_wait_enter: assert property (@(posedge clk) disable iff (!rst_n)
        s_flash_miss |=> st_r == ST_WAIT && wcnt_r == $past(flash_ws))
        else $error("flash wait not entered");
    a_wait_leave: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_r == ST_WAIT && wcnt_r == 2'h1) |=> resp_valid)
        else $error("flash wait overran");
    a_pf_hit: assert property (@(posedge clk) disable iff (!rst_n)
        (fl_acc && pf_hit) |=> resp_valid)
        else $error("prefetch hit still waited");
    a_forbid_irq: assert property (@(posedge clk) disable iff (!rst_n)
        (fl_acc && wr && flash_locked) |=> flash_irq_r)
        else $error("forbidden flash write not flagged");
    a_prot_write: assert property (@(posedge clk) disable iff (!rst_n)
        (take && !dec.undef && !misal && pif.deny_wr)
        |=> resp_abort_r && abt_cause_r == CAUSE_WRITE)
        else $error("protected write not aborted");
endmodule : sadr_top

// ---- testbench/sadr_mst.sv ----
`timescale 1ns/100ps
// ------------
// bus master model, core or dma
// ------------
module sadr_mst #(
    parameter logic ID = 1'b0
) (
    // clock and answer
    input wire logic clk,
    input wire logic gnt,
    input wire logic rv,
    input wire logic rm,
    input wire logic ab,
    // request
    output logic req,
    output logic [31:0] addr,
    output logic wr,
    output logic [1:0] sz,
    output logic fe,
    output logic us
);
    initial begin
        req = 1'b0;
        addr = 32'h0;
        wr = 1'b0;
        sz = 2'h0;
        fe = 1'b0;
        us = 1'b0;
    end

    task automatic access(input logic [31:0] a, input logic w, input logic [1:0] s,
                          input logic f, input logic u, output logic abo,
                          output time tt, output int lat);
        @(negedge clk);
        req = 1'b1;
        addr = a;
        wr = w;
        sz = s;
        fe = f;
        us = u;
        #1;
        // request held until the edge that takes it
        while (gnt !== 1'b1) begin
            @(negedge clk);
            #1;
        end
        tt = $time;
        @(negedge clk);
        req = 1'b0;
        // released lines never echo the last value
        addr = ~a;
        wr = ~w;
        sz = ~s;
        fe = ~f;
        us = ~u;
        lat = 1;
        while (!(rv === 1'b1 && rm === ID)) begin
            @(negedge clk);
            lat++;
        end
        abo = ab;
    endtask : access
endmodule : sadr_mst

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
module tb;
    import sadr_pkg::*;
    logic clk, rst_n, ce, arb_rr, arb_dma_first, flash_locked;
    logic [5:0] pls;
    logic [1:0] m_gnt, flash_ws;
    wire [1:0] m_req, m_write, m_fetch, m_user;
    wire [31:0] m_addr [2];
    wire [1:0] m_size [2];
    logic resp_valid, resp_abort_r, resp_master_r, periph_sel_r, abt_valid_r, abt_master_r;
    logic abt_write_r, abt_fetch_r, abt_user_r, remap_r, boot_flash_r, flash_irq_r;
    logic [3:0] int_sel_r;
    logic [7:0] ext_sel_r;
    logic [1:0] abt_size_r;
    logic [31:0] abt_addr_r;
    sadr_mem_t mem_sel_r;
    sadr_cause_t abt_cause_r;
    logic [15:0] prot_en, prot_no_wr, prot_no_user;
    logic [21:0] prot_base [16];
    logic [4:0] prot_log [16];
    logic ab, ab2;
    time tt, tt2;
    int lat, lat2, n_fail, samples_checked, cyc;

    sadr_top #(.WS_MAX(3)) dut_u (.clk, .rst_n, .ce, .m_req, .m_addr, .m_write, .m_size,
        .m_fetch, .m_user, .m_gnt, .arb_rr, .arb_dma_first, .resp_valid, .resp_abort_r,
        .resp_master_r, .int_sel_r, .mem_sel_r, .periph_sel_r, .ext_sel_r, .abt_clr(pls[5]),
        .abt_valid_r, .abt_master_r, .abt_cause_r, .abt_addr_r, .abt_write_r, .abt_size_r,
        .abt_fetch_r, .abt_user_r, .remap_cmd(pls[0]), .remap_r, .gp_set(pls[1]),
        .gp_clr(pls[2]), .erase(pls[3]), .boot_flash_r, .flash_ws, .flash_locked,
        .flash_irq_clr(pls[4]), .flash_irq_r, .prot_en, .prot_base, .prot_log, .prot_no_wr,
        .prot_no_user);
    sadr_mst #(.ID(1'b0)) core_u (.clk(clk), .gnt(m_gnt[0]), .rv(resp_valid),
        .rm(resp_master_r), .ab(resp_abort_r), .req(m_req[0]), .addr(m_addr[0]),
        .wr(m_write[0]), .sz(m_size[0]), .fe(m_fetch[0]), .us(m_user[0]));
    sadr_mst #(.ID(1'b1)) dma_u (.clk(clk), .gnt(m_gnt[1]), .rv(resp_valid),
        .rm(resp_master_r), .ab(resp_abort_r), .req(m_req[1]), .addr(m_addr[1]),
        .wr(m_write[1]), .sz(m_size[1]), .fe(m_fetch[1]), .us(m_user[1]));

    // ------------
    // shared tasks
    // ------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic go(input logic [31:0] a, input logic w, input logic [1:0] s,
                      input logic f, input logic u);
        core_u.access(a, w, s, f, u, ab, tt, lat);
    endtask : go

    task automatic sel(input logic [3:0] is, input sadr_mem_t m);
        chk("int_sel", int_sel_r, is);
        chk("mem_sel", mem_sel_r, m);
    endtask : sel

    task automatic pulse(input logic [5:0] v);
        @(negedge clk);
        pls = v;
        @(negedge clk);
        pls = 6'h00;
    endtask : pulse

    task automatic tie(input logic core_first);
        fork
            core_u.access(32'h0020_0000, 1'b0, SZ_WORD, 1'b0, 1'b0, ab, tt, lat);
            dma_u.access(32'h0020_0004, 1'b0, SZ_WORD, 1'b0, 1'b0, ab2, tt2, lat2);
        join
        chk("core_first", tt < tt2, core_first);
    endtask : tie

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // ------------
    // scenarios
    // ------------
    task automatic t_decode;
        for (int i = 0; i < 16; i++) begin
            go({i[3:0], 28'h030_0000}, 1'b0, SZ_WORD, 1'b0, 1'b0);
            chk("abort", ab, i > 8 && i < 15);
            chk("ext_sel", ext_sel_r, (i >= 1 && i <= 8) ? 8'h01 << (i - 1) : 8'h00);
            chk("periph", periph_sel_r, i == 15);
            sel((i == 0) ? 4'h8 : 4'h0, (i == 0) ? MEM_ROM : MEM_NONE);
            if (ab) chk("cause", abt_cause_r, CAUSE_UNDEF);
        end
        go(32'h0040_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        chk("abort", ab, 1'b1);
        $display("test decode done");
    endtask : t_decode

    task automatic t_boot;
        go(32'h0, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h1, MEM_ROM);
        go(32'h0020_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h4, MEM_SRAM);
        pulse(6'h02); // set command only
        chk("boot", boot_flash_r, 1'b1);
        go(32'h0, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h1, MEM_FLASH);
        go(32'h0030_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h8, MEM_ROM);
        pulse(6'h0A);
        chk("boot", boot_flash_r, 1'b0);
        pulse(6'h02);
        pulse(6'h04); // clear command
        chk("boot", boot_flash_r, 1'b0);
        pulse(6'h01);
        chk("remap", remap_r, 1'b1);
        go(32'h0, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h1, MEM_SRAM);
        go(32'h0020_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h4, MEM_SRAM);
        go(32'h0010_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        sel(4'h2, MEM_FLASH);
        $display("test boot done");
    endtask : t_boot

    task automatic t_align;
        dma_u.access(32'h0020_0002, 1'b1, SZ_WORD, 1'b0, 1'b0, ab, tt, lat);
        chk("abort", ab, 1'b1);
        chk("abt_rec", {abt_valid_r, abt_master_r, abt_write_r, abt_fetch_r, abt_user_r},
            5'h1C);
        chk("abt_cause", abt_cause_r, CAUSE_ALIGN);
        chk("abt_addr", abt_addr_r, 32'h0020_0002);
        chk("abt_size", abt_size_r, SZ_WORD);
        dma_u.access(32'h0020_0001, 1'b0, SZ_HALF, 1'b0, 1'b0, ab, tt, lat);
        chk("abort", ab, 1'b1);
        pulse(6'h20);
        chk("abt_valid", abt_valid_r, 1'b0);
        go(32'h0020_0002, 1'b0, SZ_HALF, 1'b0, 1'b0);
        chk("abort", ab, 1'b0);
        go(32'h0010_0002, 1'b0, SZ_WORD, 1'b1, 1'b0);
        chk("abort", ab, 1'b0); // fetch exempt
        $display("test align done");
    endtask : t_align

    task automatic t_arb;
        tie(1'b1);
        arb_dma_first = 1'b1;
        tie(1'b0);
        arb_rr = 1'b1;
        tie(1'b0);
        dma_u.access(32'h0020_0000, 1'b0, SZ_WORD, 1'b0, 1'b0, ab, tt, lat);
        tie(1'b1);
        $display("test arbiter done");
    endtask : t_arb

    task automatic t_prot;
        prot_base[0] = 22'h00_0800;
        prot_no_wr = 16'h8001;
        prot_en = 16'h8001;
        prot_base[15] = 22'h3F_FFFC;
        go(32'h0020_0000, 1'b1, SZ_WORD, 1'b0, 1'b0);
        chk("wr_abort", {ab, abt_cause_r}, {1'b1, CAUSE_WRITE});
        go(32'h0020_0400, 1'b1, SZ_WORD, 1'b0, 1'b0);
        chk("outside", ab, 1'b0); // 1 KB region
        go(32'h0020_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        chk("read_ok", ab, 1'b0);
        go(32'hFFFF_F000, 1'b1, SZ_WORD, 1'b0, 1'b0);
        chk("periph_wr", {ab, abt_cause_r}, {1'b1, CAUSE_WRITE});
        prot_log[0] = 5'h14;
        prot_no_user = 16'h0001;
        go(32'h0020_0400, 1'b0, SZ_WORD, 1'b0, 1'b1);
        chk("user", {ab, abt_cause_r, abt_user_r}, {1'b1, CAUSE_USER, 1'b1});
        prot_en = 16'h0000;
        $display("test protect done");
    endtask : t_prot

    task automatic t_flash;
        for (int w = 0; w < 4; w++) begin
            flash_ws = w[1:0];
            go(32'h0010_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
            chk("ws_lat", lat, 1 + w);
        end
        go(32'h0010_0100, 1'b0, SZ_HALF, 1'b1, 1'b0);
        chk("pf_miss", lat, 32'd4);
        go(32'h0010_0102, 1'b0, SZ_HALF, 1'b1, 1'b0);
        chk("pf_hit", lat, 32'd1);
        go(32'h0010_0104, 1'b0, SZ_HALF, 1'b1, 1'b0);
        chk("pf_next", lat, 32'd1);
        go(32'h0010_0108, 1'b0, SZ_HALF, 1'b1, 1'b0);
        chk("pf_far", lat, 32'd4);
        flash_locked = 1'b1;
        go(32'h0010_0000, 1'b0, SZ_WORD, 1'b0, 1'b0);
        @(negedge clk);
        chk("irq_rd", flash_irq_r, 1'b0);
        go(32'h0010_0000, 1'b1, SZ_WORD, 1'b0, 1'b0);
        @(negedge clk);
        chk("irq_wr", flash_irq_r, 1'b1);
        pulse(6'h10);
        chk("irq_clr", flash_irq_r, 1'b0);
        ce = 1'b0;
        pulse(6'h02);
        chk("ce_hold", boot_flash_r, 1'b0);
        ce = 1'b1;
        $display("test flash done");
    endtask : t_flash

    // ------------
    // clock, watchdog, main sequence
    // ------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        ce = 1'b1;
        rst_n = 1'b0;
        pls = 6'h00;
        arb_rr = 1'b0;
        arb_dma_first = 1'b0;
        flash_locked = 1'b0;
        flash_ws = 2'h0;
        prot_en = 16'h0000;
        prot_no_wr = 16'h0000;
        prot_no_user = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            prot_base[i] = 22'h00_0000;
            prot_log[i] = 5'h0A;
        end
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk("rst_boot", {boot_flash_r, remap_r}, 2'h0);
        t_decode();
        t_boot();
        t_align();
        t_arb();
        t_prot();
        t_flash();
        complete_run();
    end
endmodule : tb
